// >>> core/btk_bit_timer.sv
/*
 * Bit timer with on-off keying of a transmitter, edge timing on a pulse
 * input, and a generic interval mode, behind an Avalon-MM slave.
 * Assumes one system clock, a synchronous active-high reset, a pulse pin
 * that is asynchronous to the clock, and a master that holds each request
 * until waitrequest is seen low.
 */
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - Slot lasts clock period times count plus one.
// - Count is ten bits from two registers.
// - Slot clock divided from system clock by selection.
// - Timer keys the transmitter; software encodes bits.
// - Taking buffered bit sets flag 0, interrupt.
// - Zero count with empty buffer sets flag 2.
// - Flags stay readable for polling without interrupts.
// - Receive counts up, captures count at edges.
// - Rising edge sets the data bit.
// - Falling edge clears the data bit.
// - Generic timer never keys, interrupts after interval.
// - Reset returns all registers to initial values.
module btk_bit_timer
    import btk_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pulse_input_pin,
    output logic tx_key,
    output logic irq
);

    // ************************************************************
    // State and next values.
    // ************************************************************
    btk_ctrl_s ctrl_reg, ctrl_next;
    logic [7:0] cnt_lo_reg, cnt_lo_next;
    logic [2:0] st_reg, st_next;
    logic [2:0] mask_reg, mask_next;
    logic [2:0] clksel_reg, clksel_next;
    logic [7:0] pre_reg, pre_next;
    logic [9:0] cnt_reg, cnt_next;
    logic active_reg, active_next;
    logic key_reg, key_next;
    logic irq_reg, irq_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] pin_sync_reg, pin_sync_next;
    logic pin_last_reg, pin_last_next;

    // ************************************************************
    // Helper terms.
    // ************************************************************
    logic [2:0] set_w;
    logic [2:0] clr_w;
    logic wr_w;
    logic tick_w;
    logic take_w;
    logic done_w;
    logic edge_w;
    logic [7:0] pre_mask_w;
    logic [9:0] countval_w;

    // Outputs come straight from their flip-flops.
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign tx_key = key_reg;
    assign irq = irq_reg;

    // Next-state logic for the whole block.
    always_comb begin
        ctrl_next = ctrl_reg;
        cnt_lo_next = cnt_lo_reg;
        mask_next = mask_reg;
        clksel_next = clksel_reg;
        cnt_next = cnt_reg;
        active_next = active_reg;
        key_next = key_reg;
        rdata_next = rdata_reg;
        set_w = 3'h0;
        clr_w = 3'h0;
        take_w = 1'b0;
        done_w = 1'b0;
        // Two flip-flops before the pin is looked at; edges from the second.
        pin_sync_next = {pin_sync_reg[0], pulse_input_pin};
        pin_last_next = pin_sync_reg[1];
        edge_w = pin_sync_reg[1] ^ pin_last_reg;
        // One wait cycle, then the answer with waitrequest low.
        wait_next = !((avs_read || avs_write) && wait_reg);
        wr_w = avs_write && !wait_reg && avs_byteenable[0];
        // Slot tick every 2^clksel system clocks.
        pre_mask_w = 8'((9'h001 << clksel_reg) - 9'h001);
        tick_w = (pre_reg & pre_mask_w) == pre_mask_w;
        pre_next = (ctrl_reg.mode == BTK_OFF) ? 8'h00 : pre_reg + 8'h01;
        countval_w = {ctrl_reg.cnt_hi, cnt_lo_reg};

        // Mode machine.
        case (ctrl_reg.mode)
            BTK_TX, BTK_TMR: begin
                if (tick_w) begin
                    if (active_reg && cnt_reg != 10'h000) begin
                        cnt_next = cnt_reg - 10'h001;
                    end else if (ctrl_reg.mode == BTK_TMR) begin
                        // Interval over: flag it and start again.
                        done_w = active_reg;
                        active_next = 1'b1;
                        cnt_next = countval_w;
                        key_next = 1'b0;
                    end else if (ctrl_reg.full) begin
                        // Take the buffered bit and key the next slot with its value.
                        take_w = 1'b1;
                        active_next = 1'b1;
                        cnt_next = countval_w;
                        key_next = ctrl_reg.data;
                        ctrl_next.full = 1'b0;
                    end else begin
                        // Count out with nothing buffered.
                        done_w = active_reg;
                        active_next = 1'b0;
                        key_next = 1'b0;
                    end
                end
            end
            BTK_RX: begin
                key_next = 1'b0;
                if (edge_w) begin
                    // Store the elapsed count and the edge polarity.
                    cnt_lo_next = cnt_reg[7:0];
                    ctrl_next.cnt_hi = cnt_reg[9:8];
                    ctrl_next.data = pin_sync_reg[1];
                    set_w[BTK_FLAG_EDGE] = 1'b1;
                    cnt_next = 10'h000;
                end else if (tick_w && cnt_reg != BTK_CNT_MAX) begin
                    cnt_next = cnt_reg + 10'h001;
                end
            end
            default: begin
                active_next = 1'b0;
                key_next = 1'b0;
                cnt_next = 10'h000;
            end
        endcase
        set_w[BTK_FLAG_EMPTY] = take_w;
        set_w[BTK_FLAG_DONE] = done_w;

        // Register writes from software.
        if (wr_w) begin
            case (avs_address)
                BTK_OFS_COUNT: begin
                    cnt_lo_next = avs_writedata[7:0];
                end
                BTK_OFS_CTRL: begin
                    ctrl_next.cnt_hi = avs_writedata[7:6];
                    ctrl_next.mode = btk_mode_e'(avs_writedata[3:2]);
                    ctrl_next.data = avs_writedata[0];
                    // A write in transmit mode fills the one-bit buffer.
                    ctrl_next.full = (avs_writedata[3:2] == BTK_TX);
                    if (avs_writedata[3:2] != ctrl_reg.mode) begin
                        active_next = 1'b0;
                        key_next = 1'b0;
                        cnt_next = 10'h000;
                    end
                end
                BTK_OFS_STATUS: begin
                    clr_w = avs_writedata[2:0];
                end
                BTK_OFS_MASK: begin
                    mask_next = avs_writedata[2:0];
                end
                BTK_OFS_CLKPWR: begin
                    clksel_next = avs_writedata[2:0];
                end
                default: begin
                end
            endcase
        end
        // Hardware set wins over a write-one clear in the same cycle.
        st_next = (st_reg & ~clr_w) | set_w;

        // Read data, zero for unmapped offsets.
        if (avs_read && wait_reg) begin
            case (avs_address)
                BTK_OFS_COUNT: rdata_next = {24'h000000, cnt_lo_reg};
                BTK_OFS_CTRL: rdata_next = {24'h000000, ctrl_reg};
                BTK_OFS_STATUS: rdata_next = {29'h00000000, st_reg};
                BTK_OFS_MASK: rdata_next = {29'h00000000, mask_reg};
                BTK_OFS_CLKPWR: rdata_next = {29'h00000000, clksel_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        // Level interrupt while any enabled flag stands.
        irq_next = |(st_next & mask_next);
    end

    // Registers, held while the clock enable is low.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // All registers return to their initial values.
            ctrl_reg <= btk_ctrl_s'(BTK_RST_CTRL);
            cnt_lo_reg <= BTK_RST_COUNT;
            st_reg <= BTK_RST_FLAGS;
            mask_reg <= BTK_RST_FLAGS;
            clksel_reg <= BTK_RST_CLKSEL;
            pre_reg <= 8'h00;
            cnt_reg <= 10'h000;
            active_reg <= 1'b0;
            key_reg <= 1'b0;
            irq_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            pin_sync_reg <= 2'h0;
            pin_last_reg <= 1'b0;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            cnt_lo_reg <= cnt_lo_next;
            st_reg <= st_next;
            mask_reg <= mask_next;
            clksel_reg <= clksel_next;
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            active_reg <= active_next;
            key_reg <= key_next;
            irq_reg <= irq_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            pin_sync_reg <= pin_sync_next;
            pin_last_reg <= pin_last_next;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    sequence s_take;
        ce && take_w && !wr_w;
    endsequence

    sequence s_edge;
        ce && ctrl_reg.mode == BTK_RX && edge_w && !wr_w;
    endsequence

    // Captured edges split by the level that the pin went to.
    sequence s_rise;
        s_edge and pin_sync_reg[1];
    endsequence

    sequence s_fall;
        s_edge and !pin_sync_reg[1];
    endsequence

    bus_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && (avs_read || avs_write) && wait_reg |=> !avs_waitrequest)
        else $error("Bus answer not after one wait cycle.");

    irq_level_a: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 irq == |(st_reg & mask_reg))
        else $error("Interrupt does not follow masked flags.");

    empty_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        s_take |=> st_reg[BTK_FLAG_EMPTY] && tx_key == $past(ctrl_reg.data))
        else $error("Taking a bit did not set flag 0 and key.");

    slot_load_a: assert property (@(posedge clk_sys) disable iff (reset)
        s_take |=> cnt_reg == $past(countval_w))
        else $error("Slot count not loaded from count value.");

    done_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && done_w |=> st_reg[BTK_FLAG_DONE])
        else $error("Done did not set flag 2.");

    no_key_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && ctrl_reg.mode != BTK_TX |=> !tx_key)
        else $error("Transmitter keyed outside transmit mode.");

    rise_data_a: assert property (@(posedge clk_sys) disable iff (reset)
        s_rise |=> ctrl_reg.data)
        else $error("Rising edge did not set the data bit.");

    fall_data_a: assert property (@(posedge clk_sys) disable iff (reset)
        s_fall |=> !ctrl_reg.data)
        else $error("Falling edge did not clear the data bit.");

    capture_a: assert property (@(posedge clk_sys) disable iff (reset)
        s_edge |=> cnt_lo_reg == $past(cnt_reg[7:0]) && cnt_reg == 10'h000)
        else $error("Edge count not captured.");

    // A low clock enable must stretch the slot, not shorten it.
    freeze_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        !ce |=> cnt_reg == $past(cnt_reg) && tx_key == $past(tx_key))
        else $error("Slot state moved while the clock enable was low.");

    reset_init_a: assert property (@(posedge clk_sys)
        reset |=> ctrl_reg == btk_ctrl_s'(BTK_RST_CTRL) && !irq && !tx_key)
        else $error("Reset did not restore registers.");

endmodule : btk_bit_timer

// >>> common/btk_pkg.sv
/*
 * Package of the bit timer with on-off keying: register offsets, field
 * layouts, reset values, timing constants, the mode enumeration and the
 * control register struct.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, registers in byte 0.
 */
package btk_pkg;

    // ************************************************************
    // Register map, byte addresses.
    // ************************************************************
    localparam logic [4:0] BTK_OFS_COUNT = 5'h00;
    localparam logic [4:0] BTK_OFS_CTRL = 5'h04;
    localparam logic [4:0] BTK_OFS_STATUS = 5'h08;
    localparam logic [4:0] BTK_OFS_MASK = 5'h0C;
    localparam logic [4:0] BTK_OFS_CLKPWR = 5'h10;

    // ************************************************************
    // Status and mask bit positions.
    // ************************************************************
    localparam int BTK_FLAG_EMPTY = 0; // Buffer empty, vector 0x04.
    localparam int BTK_FLAG_EDGE = 1; // Receive edge captured.
    localparam int BTK_FLAG_DONE = 2; // Transmission or interval done, vector 0x02.

    // ************************************************************
    // Reset values and counts.
    // ************************************************************
    localparam logic [7:0] BTK_RST_COUNT = 8'h00;
    localparam logic [7:0] BTK_RST_CTRL = 8'h00;
    localparam logic [2:0] BTK_RST_FLAGS = 3'h0;
    localparam logic [2:0] BTK_RST_CLKSEL = 3'h0;
    localparam logic [9:0] BTK_CNT_MAX = 10'h3FF;
    localparam int BTK_CLK_NS = 50; // System clock period.
    localparam int BTK_BUS_WAIT = 1; // Wait cycles before each answer.

    // ************************************************************
    // Modes and control register layout.
    // ************************************************************
    typedef enum logic [1:0] {
        BTK_OFF = 2'b00,
        BTK_TX = 2'b01,
        BTK_RX = 2'b10,
        BTK_TMR = 2'b11
    } btk_mode_e;

    typedef struct packed {
        logic [1:0] cnt_hi; // Upper two bits of the count value.
        logic [1:0] rsv; // Reads as zero.
        btk_mode_e mode; // Operating mode.
        logic full; // A bit waits in the data bit, read only.
        logic data; // Next bit to send, or last edge polarity.
    } btk_ctrl_s;

endpackage : btk_pkg

// >>> tb/btk_far_side.sv
/*
 * Far-side model: the transmitter keying path and an external receiver.
 * Assumes one system clock; the bench calls send_edge to move the pulse pin.
 */
`timescale 1ns/1ns
module btk_far_side (
    input wire logic clk_sys,
    input wire logic tx_key,
    output logic pulse_input_pin
);
    int key_len = 0; // Length in clocks of the last keyed stretch.
    int key_runs = 0; // Number of keyed stretches seen.
    int run = 0;

    // Measures each keyed stretch of the carrier once it ends.
    always @(posedge clk_sys) begin
        if (tx_key === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            key_len <= run;
            key_runs <= key_runs + 1;
            run <= 0;
        end
    end

    initial pulse_input_pin = 1'b0;

    // Receiver output changes level after a gap, right after a clock edge.
    task send_edge(input logic lvl, input int gap);
        repeat (gap) @(posedge clk_sys);
        pulse_input_pin <= lvl;
    endtask : send_edge
endmodule : btk_far_side

// >>> tb/bit_timer_ook_keying_bench.sv
/*
 * Self-checking bench of the bit timer: registers, transmit slots, receive
 * capture and the generic timer. Assumes the register map of btk_pkg.
 */
`timescale 1ns/1ns
module bit_timer_ook_keying_bench;
    import btk_pkg::*;
    logic clk_sys, reset, ce, avs_read, avs_write, avs_waitrequest, pulse_input_pin, tx_key, irq;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] q;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    btk_bit_timer i_btk_bit_timer (.clk_sys(clk_sys), .reset(reset), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pulse_input_pin(pulse_input_pin), .tx_key(tx_key), .irq(irq));
    btk_far_side i_far (.clk_sys(clk_sys), .tx_key(tx_key), .pulse_input_pin(pulse_input_pin));

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    // Compares one value and counts it.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task conclude;
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // One Avalon access, held until waitrequest is sampled low.
    task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h000000, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Polls the status register until the given flag is set.
    task wait_flag(input int idx);
        for (int i = 0; i < 400; i++) begin
            bus(1'b0, BTK_OFS_STATUS, 8'h00);
            if (q[idx] === 1'b1) break;
        end
    endtask : wait_flag

    // ************************************************************
    // Scenarios.
    // ************************************************************
    // Every register reads zero after reset; unmapped places and writes without byte 0 are ignored.
    task t_reset;
        bus(1'b1, 5'h14, 8'hFF);
        avs_byteenable <= 4'hE;
        bus(1'b1, BTK_OFS_COUNT, 8'hFF);
        avs_byteenable <= 4'hF;
        for (int a = 0; a <= 5'h14; a += 4) begin
            bus(1'b0, a[4:0], 8'h00);
            chk(avs_readdata, 32'h00000000);
        end
    endtask : t_reset

    // Sends two keyed bits back to back, pauses the clock enable for 20 cycles, and times the stretch.
    task t_transmit(input logic [2:0] sel, input logic [9:0] cv);
        int runs;
        runs = i_far.key_runs;
        bus(1'b1, BTK_OFS_CLKPWR, {5'h00, sel});
        bus(1'b1, BTK_OFS_COUNT, cv[7:0]);
        bus(1'b1, BTK_OFS_MASK, 8'h05);
        bus(1'b1, BTK_OFS_CTRL, {cv[9:8], 2'b00, BTK_TX, 2'b01});
        wait_flag(BTK_FLAG_EMPTY);
        chk(q[BTK_FLAG_EMPTY], 1'b1);
        bus(1'b1, BTK_OFS_STATUS, 8'h01);
        bus(1'b1, BTK_OFS_CTRL, {cv[9:8], 2'b00, BTK_TX, 2'b01});
        ce <= 1'b0;
        repeat (20) @(posedge clk_sys);
        ce <= 1'b1;
        wait_flag(BTK_FLAG_DONE);
        chk(q[2:0], 3'h5);
        chk(irq, 1'b1);
        chk(i_far.key_runs, runs + 1);
        chk(i_far.key_len, 2 * (2 ** sel) * (cv + 1) + 20);
        bus(1'b1, BTK_OFS_CTRL, 8'h00);
        bus(1'b1, BTK_OFS_STATUS, 8'h05);
        bus(1'b0, BTK_OFS_STATUS, 8'h00);
        chk(q, 8'h00);
        chk(irq, 1'b0);
    endtask : t_transmit

    // Captures two pulse edges and their polarity.
    task t_receive;
        bus(1'b1, BTK_OFS_CLKPWR, 8'h00);
        bus(1'b1, BTK_OFS_CTRL, {4'h0, BTK_RX, 2'b00});
        i_far.send_edge(1'b1, 40);
        repeat (6) @(posedge clk_sys);
        bus(1'b0, BTK_OFS_COUNT, 8'h00);
        chk(q >= 8'd38 && q <= 8'd46, 1'b1);
        bus(1'b0, BTK_OFS_CTRL, 8'h00);
        chk(q[0], 1'b1);
        bus(1'b1, BTK_OFS_STATUS, 8'h02);
        i_far.send_edge(1'b0, 20);
        repeat (6) @(posedge clk_sys);
        bus(1'b0, BTK_OFS_STATUS, 8'h00);
        chk(q[BTK_FLAG_EDGE], 1'b1);
        bus(1'b0, BTK_OFS_CTRL, 8'h00);
        chk(q[0], 1'b0);
        bus(1'b1, BTK_OFS_CTRL, 8'h00);
        bus(1'b1, BTK_OFS_STATUS, 8'h07);
    endtask : t_receive

    // Generic timer: polled with the interrupt masked, never keys.
    task t_timer;
        int runs;
        runs = i_far.key_runs;
        bus(1'b1, BTK_OFS_MASK, 8'h00);
        bus(1'b1, BTK_OFS_COUNT, 8'h04);
        bus(1'b1, BTK_OFS_CTRL, {4'h0, BTK_TMR, 2'b01});
        wait_flag(BTK_FLAG_DONE);
        chk(q[BTK_FLAG_DONE], 1'b1);
        chk(irq, 1'b0);
        bus(1'b1, BTK_OFS_MASK, 8'h04);
        bus(1'b0, BTK_OFS_MASK, 8'h00);
        chk(irq, 1'b1);
        chk(i_far.key_runs, runs);
        chk(tx_key, 1'b0);
        bus(1'b1, BTK_OFS_CTRL, 8'h00);
    endtask : t_timer

    // ************************************************************
    // Clock, timeout and main sequence.
    // ************************************************************
    // Makes the 20 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Cuts a hang short.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // Resets the block, then runs every scenario.
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_transmit(3'h0, 10'h102);
        t_transmit(3'h1, 10'h010);
        t_receive();
        t_timer();
        // A second reset in mid-run must clear what the scenarios left behind.
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        conclude();
    end
endmodule : bit_timer_ook_keying_bench
